// ===== common/pslv_pkg.sv
// package: bit positions, offsets, reset values and widths for the status vector latching block
package pslv_pkg;
    // ---------------------------------------------------------------
    // vector widths
    // ---------------------------------------------------------------
    localparam int CFG_W  = 536;
    localparam int STS_W  = 448;
    // ---------------------------------------------------------------
    // control vector pulse bits (base of the 8-bit pulse group)
    // ---------------------------------------------------------------
    localparam int CFG_PULSE_LSB   = 512;
    localparam int PL_SET_PMA_LINK = 0;   // control bit 512
    localparam int PL_CLR_PMA_FLT  = 1;   // control bit 513
    localparam int PL_SET_PCS_LINK = 4;   // control bit 516
    localparam int PL_CLR_PCS_FLT  = 5;   // control bit 517
    localparam int PL_CLR_STATUS2  = 6;   // control bit 518
    localparam int PL_CLR_TP_CNT   = 7;   // control bit 519
    // ---------------------------------------------------------------
    // status vector positions
    // ---------------------------------------------------------------
    localparam int SV_PMA_LINK   = 18;
    localparam int SV_PMA_FAULT  = 23;
    localparam int SV_PMA_RXF    = 42;
    localparam int SV_PMA_TXF    = 43;
    localparam int SV_SIG_DET    = 48;
    localparam int SV_INFO_LSB   = 192;
    localparam int SV_INFO_MSB   = 207;
    localparam int SV_PCS_LINK   = 226;
    localparam int SV_PCS_FAULT  = 231;
    localparam int SV_PCS_RXF    = 250;
    localparam int SV_PCS_TXF    = 251;
    localparam int SV_LOCK       = 256;
    localparam int SV_HIBER      = 257;
    localparam int SV_ALIGN      = 268;
    localparam int SV_ERRB_LSB   = 272;
    localparam int SV_ERRB_MSB   = 279;
    localparam int SV_BER_LSB    = 280;
    localparam int SV_BER_MSB    = 285;
    localparam int SV_LH_HIBER   = 286;
    localparam int SV_LL_LOCK    = 287;
    localparam int SV_TP_LSB     = 288;
    localparam int SV_TP_MSB     = 303;
    // ---------------------------------------------------------------
    // counter widths and latch reset values
    // ---------------------------------------------------------------
    localparam int ERRB_W = 8;
    localparam int BER_W  = 6;
    localparam int TP_W   = 16;
    localparam int NLL    = 3;
    localparam int NLH    = 5;
    localparam logic [NLL-1:0] LL_RST = 3'h0;
    localparam logic [NLH-1:0] LH_RST = 5'h01;
    // ---------------------------------------------------------------
    // register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_PULSE  = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_COUNT  = 8'h08;
    localparam logic [7:0] OFS_IRQ_ST = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MK = 8'h10;
    localparam logic [7:0] OFS_INFO   = 8'h14;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam int NIRQ = 8;
endpackage

// ===== rtl/pslv_reset_sync.sv
// reset synchroniser: asynchronous assertion, release on the clock
module pslv_reset_sync (
    // clock and raw reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // synchronised reset
    output logic      rst_sync_n
);
    logic stage1_reg;
    logic stage2_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= 1'b1;
            stage2_reg <= stage1_reg;
        end
    end

    assign rst_sync_n = stage2_reg;
endmodule // pslv_reset_sync

// ===== rtl/pslv_sat_counter.sv
// saturating event counter with a clear pulse; a count in the clear cycle survives
module pslv_sat_counter #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // control
    input  wire logic             inc,
    input  wire logic             clr,
    // value
    output logic [WIDTH-1:0]      count
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    wire              at_max = &count_reg;

    assign count_next = clr ? {{(WIDTH-1){1'b0}}, inc}
                      : (inc && !at_max) ? count_reg + 1'b1 : count_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;
endmodule // pslv_sat_counter

// ===== rtl/pslv_top.sv
// status vector latching block: latches, counters, status vector, interrupt and AHB-Lite slave
// Notes on behaviour
// - link and lock latches drop, set by pulse
// - high-error latch rises, cleared by status-2 pulse
// - pma fault latches cleared by pma pulse
// - pcs fault latches cleared by pcs pulse
// - test-pattern counter cleared by its pulse
// - errored-block and error-rate counters in vector
// - lock, high-error, alignment as single bits
// - test-pattern count in upper field
// - older variant drives fault bits to zero
// - separate receive and transmit fault latches
// - signal detect reported as one bit
// - newer variant carries core information field
// - resets synchronised to the core clock
// - lock bit follows receiver block synchronisation
// - high-error bit follows live error condition
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
module pslv_top #(
    parameter bit          NEWER_VARIANT = 1'b1,
    parameter logic [15:0] CORE_INFO     = 16'h0A5C   // arbitrary value
) (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        resetn,
    // control vector from user logic
    input  wire logic [pslv_pkg::CFG_W-1:0]  configuration_vector,
    // receiver conditions and transmit faults
    input  wire logic                        pma_rx_link_up,
    input  wire logic                        pcs_rx_link_up,
    input  wire logic                        block_lock,
    input  wire logic                        high_error_rate_flag,
    input  wire logic                        rx_align_link,
    input  wire logic                        signal_detect,
    input  wire logic                        pma_rx_fault,
    input  wire logic                        pma_tx_fault,
    input  wire logic                        pcs_rx_fault,
    input  wire logic                        pcs_tx_fault,
    // counter events
    input  wire logic                        errored_block_evt,
    input  wire logic                        ber_evt,
    input  wire logic                        test_pattern_err_evt,
    // status vector
    output logic [pslv_pkg::STS_W-1:0]       status_vector,
    // interrupt
    output logic                             irq,
    // AHB-Lite slave
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic                             hresp,
    output logic [31:0]                      hrdata
);
    // ---------------------------------------------------------------
    // reset
    // ---------------------------------------------------------------
    logic rst_n;

    pslv_reset_sync u_rst (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .rst_sync_n (rst_n)
    );

    // ---------------------------------------------------------------
    // AHB-Lite decode
    // ---------------------------------------------------------------
    logic       dp_wr_reg;
    logic [7:0] dp_addr_reg;
    logic [31:0] hrdata_reg;

    wire        ap_take   = hsel && htrans[1] && hready;
    wire        ap_read   = ap_take && !hwrite;
    wire        wr_pulse  = dp_wr_reg && (dp_addr_reg == pslv_pkg::OFS_PULSE);
    wire        wr_irq_st = dp_wr_reg && (dp_addr_reg == pslv_pkg::OFS_IRQ_ST);
    wire        wr_irq_mk = dp_wr_reg && (dp_addr_reg == pslv_pkg::OFS_IRQ_MK);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dp_wr_reg   <= 1'b0;
            dp_addr_reg <= 8'h00;
        end else begin
            dp_wr_reg   <= ap_take && hwrite;
            dp_addr_reg <= haddr[7:0];
        end
    end

    // ---------------------------------------------------------------
    // control pulses: user vector or a write-one to the pulse register
    // ---------------------------------------------------------------
    wire [7:0] pl = configuration_vector[pslv_pkg::CFG_PULSE_LSB +: 8]
                  | (wr_pulse ? hwdata[7:0] : 8'h00);

    // ---------------------------------------------------------------
    // latch-low bits: pma link, pcs link, block lock
    // ---------------------------------------------------------------
    logic [pslv_pkg::NLL-1:0] ll_reg;
    wire  [pslv_pkg::NLL-1:0] ll_cond = {block_lock, pcs_rx_link_up, pma_rx_link_up};
    wire  [pslv_pkg::NLL-1:0] ll_set  = {pl[pslv_pkg::PL_CLR_STATUS2],
                                         pl[pslv_pkg::PL_SET_PCS_LINK],
                                         pl[pslv_pkg::PL_SET_PMA_LINK]};

    // ---------------------------------------------------------------
    // latch-high bits: high error, pma rx/tx fault, pcs rx/tx fault
    // ---------------------------------------------------------------
    logic [pslv_pkg::NLH-1:0] lh_reg;
    wire  [3:0] flt_raw = {pcs_tx_fault, pcs_rx_fault, pma_tx_fault, pma_rx_fault};
    wire  [pslv_pkg::NLH-1:0] lh_cond = {flt_raw & {4{NEWER_VARIANT}},
                                         high_error_rate_flag};
    wire  [pslv_pkg::NLH-1:0] lh_clr  = {pl[pslv_pkg::PL_CLR_PCS_FLT],
                                         pl[pslv_pkg::PL_CLR_PCS_FLT],
                                         pl[pslv_pkg::PL_CLR_PMA_FLT],
                                         pl[pslv_pkg::PL_CLR_PMA_FLT],
                                         pl[pslv_pkg::PL_CLR_STATUS2]};

    genvar gi;
    generate
        for (gi = 0; gi < pslv_pkg::NLL; gi++) begin : g_ll
            // a low condition wins over the set pulse
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    ll_reg[gi] <= pslv_pkg::LL_RST[gi];
                end else if (!ll_cond[gi]) begin
                    ll_reg[gi] <= 1'b0;
                end else if (ll_set[gi]) begin
                    ll_reg[gi] <= 1'b1;
                end
            end
        end
        for (gi = 0; gi < pslv_pkg::NLH; gi++) begin : g_lh
            // a high condition wins over the clear pulse
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    lh_reg[gi] <= pslv_pkg::LH_RST[gi];
                end else if (lh_cond[gi]) begin
                    lh_reg[gi] <= 1'b1;
                end else if (lh_clr[gi]) begin
                    lh_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // live bits
    // ---------------------------------------------------------------
    logic lock_reg;
    logic hiber_reg;
    logic align_reg;
    logic sigdet_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock_reg   <= 1'b0;
            hiber_reg  <= 1'b0;
            align_reg  <= 1'b0;
            sigdet_reg <= 1'b0;
        end else begin
            lock_reg   <= block_lock;
            hiber_reg  <= high_error_rate_flag;
            align_reg  <= rx_align_link;
            sigdet_reg <= signal_detect;
        end
    end

    // ---------------------------------------------------------------
    // counters
    // ---------------------------------------------------------------
    logic [pslv_pkg::ERRB_W-1:0] errb_cnt;
    logic [pslv_pkg::BER_W-1:0]  ber_cnt;
    logic [pslv_pkg::TP_W-1:0]   tp_cnt;

    pslv_sat_counter #(.WIDTH(pslv_pkg::ERRB_W)) u_errb (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .inc     (errored_block_evt),
        .clr     (pl[pslv_pkg::PL_CLR_STATUS2]),
        .count   (errb_cnt)
    );
    pslv_sat_counter #(.WIDTH(pslv_pkg::BER_W)) u_ber (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .inc     (ber_evt),
        .clr     (pl[pslv_pkg::PL_CLR_STATUS2]),
        .count   (ber_cnt)
    );
    pslv_sat_counter #(.WIDTH(pslv_pkg::TP_W)) u_tp (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .inc     (test_pattern_err_evt),
        .clr     (pl[pslv_pkg::PL_CLR_TP_CNT]),
        .count   (tp_cnt)
    );

    // ---------------------------------------------------------------
    // status vector
    // ---------------------------------------------------------------
    wire [15:0] info = NEWER_VARIANT ? CORE_INFO : 16'h0000;

    always_comb begin
        status_vector = '0;
        status_vector[pslv_pkg::SV_PMA_LINK]  = ll_reg[0];
        status_vector[pslv_pkg::SV_PCS_LINK]  = ll_reg[1];
        status_vector[pslv_pkg::SV_LL_LOCK]   = ll_reg[2];
        status_vector[pslv_pkg::SV_LH_HIBER]  = lh_reg[0];
        status_vector[pslv_pkg::SV_PMA_RXF]   = lh_reg[1];
        status_vector[pslv_pkg::SV_PMA_TXF]   = lh_reg[2];
        status_vector[pslv_pkg::SV_PCS_RXF]   = lh_reg[3];
        status_vector[pslv_pkg::SV_PCS_TXF]   = lh_reg[4];
        status_vector[pslv_pkg::SV_PMA_FAULT] = lh_reg[1] | lh_reg[2];
        status_vector[pslv_pkg::SV_PCS_FAULT] = lh_reg[3] | lh_reg[4];
        status_vector[pslv_pkg::SV_SIG_DET]   = sigdet_reg;
        status_vector[pslv_pkg::SV_LOCK]      = lock_reg;
        status_vector[pslv_pkg::SV_HIBER]     = hiber_reg;
        status_vector[pslv_pkg::SV_ALIGN]     = align_reg;
        status_vector[pslv_pkg::SV_INFO_MSB:pslv_pkg::SV_INFO_LSB] = info;
        status_vector[pslv_pkg::SV_ERRB_MSB:pslv_pkg::SV_ERRB_LSB] = errb_cnt;
        status_vector[pslv_pkg::SV_BER_MSB:pslv_pkg::SV_BER_LSB]   = ber_cnt;
        status_vector[pslv_pkg::SV_TP_MSB:pslv_pkg::SV_TP_LSB]     = tp_cnt;
    end

    // ---------------------------------------------------------------
    // interrupt: latch-low drops and latch-high rises
    // ---------------------------------------------------------------
    logic [pslv_pkg::NIRQ-1:0] irq_st_reg;
    logic [pslv_pkg::NIRQ-1:0] irq_mk_reg;
    wire  [pslv_pkg::NIRQ-1:0] irq_evt = {lh_cond & ~lh_reg, ll_reg & ~ll_cond};
    wire  [pslv_pkg::NIRQ-1:0] irq_w1c = wr_irq_st ? hwdata[pslv_pkg::NIRQ-1:0] : '0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_st_reg <= '0;
            irq_mk_reg <= pslv_pkg::IRQ_MASK_RST;
        end else begin
            irq_st_reg <= (irq_st_reg & ~irq_w1c) | irq_evt;
            if (wr_irq_mk) begin
                irq_mk_reg <= hwdata[pslv_pkg::NIRQ-1:0];
            end
        end
    end

    assign irq = |(irq_st_reg & irq_mk_reg);

    // ---------------------------------------------------------------
    // read mux, registered at the address phase
    // ---------------------------------------------------------------
    wire [31:0] st_word = {20'h00000, sigdet_reg, align_reg, hiber_reg, lock_reg,
                           lh_reg, ll_reg};
    wire [31:0] cnt_word = {tp_cnt, 2'h0, ber_cnt, errb_cnt};
    wire [7:0]  ra = haddr[7:0];
    wire [31:0] rd_mux = (ra == pslv_pkg::OFS_STATUS) ? st_word
                       : (ra == pslv_pkg::OFS_COUNT)  ? cnt_word
                       : (ra == pslv_pkg::OFS_IRQ_ST) ? {24'h000000, irq_st_reg}
                       : (ra == pslv_pkg::OFS_IRQ_MK) ? {24'h000000, irq_mk_reg}
                       : (ra == pslv_pkg::OFS_INFO)   ? {16'h0000, info}
                       : 32'h00000000;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_reg <= 32'h00000000;
        end else if (ap_read) begin
            hrdata_reg <= rd_mux;
        end
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence lock_lost_s;
        !block_lock;
    endsequence
    sequence lock_back_unset_s;
        block_lock && !pl[pslv_pkg::PL_CLR_STATUS2];
    endsequence

    lock_stays_low_a: assert property (lock_lost_s ##1 lock_back_unset_s |=> !status_vector[pslv_pkg::SV_LL_LOCK]) else $error("latched lock rose without set pulse");
    link_set_a: assert property (pma_rx_link_up && pl[pslv_pkg::PL_SET_PMA_LINK] |=> status_vector[pslv_pkg::SV_PMA_LINK]) else $error("pma link latch not set");
    hiber_latch_a: assert property (high_error_rate_flag |=> status_vector[pslv_pkg::SV_LH_HIBER] ##0 status_vector[pslv_pkg::SV_HIBER]) else $error("high error not latched");
    hiber_clear_a: assert property (!high_error_rate_flag && pl[pslv_pkg::PL_CLR_STATUS2] |=> !status_vector[pslv_pkg::SV_LH_HIBER]) else $error("high error latch not cleared");
    pma_flt_clr_a: assert property (!pma_rx_fault && pl[pslv_pkg::PL_CLR_PMA_FLT] |=> !status_vector[pslv_pkg::SV_PMA_RXF]) else $error("pma rx fault not cleared");
    pcs_flt_clr_a: assert property (!pcs_tx_fault && pl[pslv_pkg::PL_CLR_PCS_FLT] |=> !status_vector[pslv_pkg::SV_PCS_TXF]) else $error("pcs tx fault not cleared");
    tp_clear_a: assert property (pl[pslv_pkg::PL_CLR_TP_CNT] && !test_pattern_err_evt |=> tp_cnt == 16'h0000) else $error("test pattern count not zeroed");
    errb_sat_a: assert property (errb_cnt == 8'hFF && !pl[pslv_pkg::PL_CLR_STATUS2] |=> errb_cnt == 8'hFF) else $error("errored block count wrapped");
    old_zero_a: assert property (!NEWER_VARIANT |-> !status_vector[pslv_pkg::SV_PMA_FAULT] && !status_vector[pslv_pkg::SV_PCS_FAULT]) else $error("older variant fault bit set");
    lock_live_a: assert property (status_vector[pslv_pkg::SV_LOCK] == $past(block_lock)) else $error("lock bit lags its source");
    irq_level_a: assert property (irq_evt[0] && irq_mk_reg[0] && !wr_irq_mk |=> irq) else $error("unmasked interrupt not raised");
endmodule // pslv_top

// ===== bench/pslv_user_model.sv
// user-side model: drives the pulse group of the control vector
module pslv_user_model (
    // clock
    input  wire logic                   clk_sys,
    // control vector
    output logic [pslv_pkg::CFG_W-1:0]  configuration_vector
);
    timeunit 1ns;
    timeprecision 1ns;
    initial configuration_vector = '0;
    // pulse bits stand for exactly one cycle
    task automatic pulse(input logic [7:0] bits);
        @(posedge clk_sys);
        configuration_vector[pslv_pkg::CFG_PULSE_LSB +: 8] <= bits;
        @(posedge clk_sys);
        configuration_vector <= '0;
    endtask
endmodule // pslv_user_model

// ===== bench/pslv_top_tb_top.sv
// testbench: status vector latches, counters, interrupt and register bus
module pslv_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] INFO = 16'h1234;   // arbitrary value
    logic                        clk_sys = 1'b0;
    logic                        resetn = 1'b0;
    logic [pslv_pkg::CFG_W-1:0]  cfg;
    logic [pslv_pkg::STS_W-1:0]  sv;
    logic pma_up, pcs_up, lock, hiber, align, sigdet, prf, ptf, crf, ctf, eb, be, tp;
    logic hsel, hwrite, hrdy, hresp, irq;
    logic [1:0]                  htrans;
    logic [2:0]                  hsize;
    logic [31:0]                 haddr, hwdata, hrdata, rd;
    int                          failures = 0;
    int                          checks_done = 0;
    always #50 clk_sys = ~clk_sys;
    pslv_user_model u_user (.clk_sys(clk_sys), .configuration_vector(cfg));
    pslv_top #(.NEWER_VARIANT(1'b1), .CORE_INFO(INFO)) u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .configuration_vector(cfg),
        .pma_rx_link_up(pma_up), .pcs_rx_link_up(pcs_up), .block_lock(lock),
        .high_error_rate_flag(hiber), .rx_align_link(align), .signal_detect(sigdet),
        .pma_rx_fault(prf), .pma_tx_fault(ptf), .pcs_rx_fault(crf), .pcs_tx_fault(ctf),
        .errored_block_evt(eb), .ber_evt(be), .test_pattern_err_evt(tp),
        .status_vector(sv), .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
        .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata));
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge clk_sys); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hrdy !== 1'b1);
        rd = hrdata;
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        give_verdict();
    end
    initial begin
        {pma_up, pcs_up, lock, hiber, align, sigdet, prf, ptf, crf, ctf, eb, be, tp} = '0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        step(4);
        chk({sv[286], sv[18], irq}, 32'h4);
        resetn <= 1'b1;
        step(4);
        $display("test reset done");
        {pma_up, pcs_up, lock} <= 3'h7;
        step(2);
        u_user.pulse(8'h51);
        step(1);
        chk({sv[287], sv[226], sv[18], sv[286]}, 32'hE);
        ahb(1'b1, pslv_pkg::OFS_IRQ_MK, 32'h1);
        chk(irq, 32'h0);
        pma_up <= 1'b0;
        step(1);
        pma_up <= 1'b1;
        step(2);
        chk(sv[18], 32'h0);
        chk(irq, 32'h1);
        ahb(1'b1, pslv_pkg::OFS_IRQ_ST, 32'h1);
        chk(irq, 32'h0);
        ahb(1'b0, pslv_pkg::OFS_STATUS, 32'h0);
        chk(rd, 32'h106);
        u_user.pulse(8'h01);
        step(1);
        chk(sv[18], 32'h1);
        $display("test latch low done");
        {align, sigdet, hiber} <= 3'h7;
        step(2);
        chk({sv[268], sv[257], sv[256], sv[48]}, 32'hF);
        {hiber, lock, align, sigdet} <= 4'h0;
        step(2);
        chk({sv[257], sv[256], sv[286], sv[287]}, 32'h2);
        chk({sv[268], sv[48]}, 32'h0);
        ahb(1'b1, pslv_pkg::OFS_PULSE, 32'h40);
        chk({sv[286], sv[287]}, 32'h0);
        $display("test latch high done");
        {prf, ctf} <= 2'h3;
        step(1);
        {prf, ctf} <= 2'h0;
        step(2);
        chk({sv[251], sv[250], sv[231], sv[43], sv[42], sv[23]}, 32'h2B);
        u_user.pulse(8'h02);
        step(1);
        chk({sv[251], sv[43], sv[42], sv[23]}, 32'h8);
        u_user.pulse(8'h20);
        step(1);
        chk({sv[251], sv[231]}, 32'h0);
        {ptf, crf} <= 2'h3;
        step(1);
        {ptf, crf} <= 2'h0;
        step(2);
        chk({sv[251], sv[250], sv[43], sv[42]}, 32'h6);
        u_user.pulse(8'h22);
        step(1);
        chk({sv[250], sv[231], sv[43], sv[23]}, 32'h0);
        $display("test faults done");
        {eb, be, tp} <= 3'h7;
        step(5);
        tp <= 1'b0;
        step(295);
        {eb, be} <= 2'h0;
        step(2);
        chk(sv[303:272], 32'h00053FFF);
        ahb(1'b0, pslv_pkg::OFS_COUNT, 32'h0);
        chk(rd, 32'h00053FFF);
        u_user.pulse(8'h80);
        step(1);
        chk(sv[303:272], 32'h00003FFF);
        u_user.pulse(8'h40);
        step(1);
        chk(sv[285:272], 32'h0);
        $display("test counters done");
        chk(sv[207:192], {16'h0000, INFO});
        ahb(1'b0, pslv_pkg::OFS_INFO, 32'h0);
        chk(rd, {16'h0000, INFO});
        ahb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        $display("test info done");
        give_verdict();
    end
endmodule // pslv_top_tb_top
